/* File: inc/lppc_pkg.sv */
package lppc_pkg;

    // Exception level of the requesting core.
    typedef enum logic [1:0] {
        LPPC_EL0 = 2'h0,
        LPPC_EL1 = 2'h1,
        LPPC_EL2 = 2'h2,
        LPPC_EL3 = 2'h3
    } lppc_el_t;

    // Register selected by an access, one-hot.
    typedef enum logic [3:0] {
        LPPC_SEL_NONE  = 4'h1,
        LPPC_SEL_MISS  = 4'h2,
        LPPC_SEL_PART  = 4'h4,
        LPPC_SEL_POWER = 4'h8
    } lppc_sel_t;

endpackage

/* File: inc/lppc_regs.svh */
`ifndef LPPC_REGS_SVH
`define LPPC_REGS_SVH

// ----------------------------------------------------------------------------
// System-register coordinates of both execution-state views (coproc for the 32-bit view only, op0 for the 64-bit view only)
// ----------------------------------------------------------------------------
`define LPPC_COPROC_NUM      4'hF
`define LPPC_OP0_SYSREG      2'h3
`define LPPC_OP1_NUM         3'h0
`define LPPC_CRN_NUM         4'hF
`define LPPC_CRM_COUNTERS    4'h4
`define LPPC_CRM_CONTROL     4'h3
`define LPPC_OP2_MISS        3'h6
`define LPPC_OP2_PARTITION   3'h3
`define LPPC_OP2_POWER       3'h5

// ----------------------------------------------------------------------------
// Widths, field positions and reset values
// ----------------------------------------------------------------------------
`define LPPC_REG_W           32
`define LPPC_XFER_W          64
`define LPPC_MISS_RESET      32'h0000_0000
`define LPPC_MISS_MAX        32'hFFFF_FFFF
`define LPPC_PART_RESET      32'h0000_0000
`define LPPC_PORTION_LSB     4
`define LPPC_PORTION_MSB     7
`define LPPC_SCHEME_CNT      8
`define LPPC_GROUP_CNT       4
`define LPPC_FALLBACK_GROUP  4'h1

`endif

/* File: rtl/lppc_regs_top.sv */
`timescale 1ns/1ps
`include "lppc_regs.svh"

module lppc_regs_top #(
    parameter int SCHEMES = `LPPC_SCHEME_CNT,
    parameter int GROUPS  = `LPPC_GROUP_CNT
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          sys_rst_i,
    // System-register access port.
    input  wire logic                          acc_valid_i,
    input  wire logic                          acc_write_i,
    input  wire logic                          acc_view64_i,
    input  wire logic [1:0]                    acc_op0_i,
    input  wire logic [3:0]                    acc_coproc_i,
    input  wire logic [2:0]                    acc_op1_i,
    input  wire logic [3:0]                    acc_crn_i,
    input  wire logic [3:0]                    acc_crm_i,
    input  wire logic [2:0]                    acc_op2_i,
    input  wire logic [1:0]                    acc_el_i,
    input  wire logic [`LPPC_XFER_W-1:0]       acc_wdata_i,
    output logic                               acc_ack_o,
    output logic                               acc_undef_o,
    output logic                               acc_trap_o,
    output logic      [`LPPC_XFER_W-1:0]       acc_rdata_o,
    // Privilege and security controls.
    input  wire logic                          top_level_power_reg_write_en_i,
    input  wire logic                          hyp_level_power_reg_write_en_i,
    input  wire logic                          top_level_partition_write_en_i,
    input  wire logic                          hyp_level_partition_write_en_i,
    input  wire logic                          nonsecure_state_flag_i,
    input  wire logic                          secure_event_count_enable_i,
    // L3 miss events.
    input  wire logic                          miss_event_i,
    input  wire logic                          miss_secure_i,
    // Way-group allocation lookup.
    input  wire logic [$clog2(SCHEMES)-1:0]    alloc_scheme_i,
    output logic      [GROUPS-1:0]             alloc_group_mask_o,
    // Power channel.
    input  wire logic [3:0]                    pchannel_init_portion_i,
    output logic      [19:16]                  cluster_power_activity_out_o
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [`LPPC_REG_W-1:0]        miss_q;
    logic [`LPPC_REG_W-1:0]        miss_d;
    logic [SCHEMES*GROUPS-1:0]     part_q;
    logic [SCHEMES*GROUPS-1:0]     part_d;
    // Only the portion field of the power register is stored; the rest reads as zero.
    logic [3:0]                    portion_q;
    logic [3:0]                    portion_d;

    logic                          ack_q;
    logic                          undef_q;
    logic                          trap_q;
    logic [`LPPC_XFER_W-1:0]       rdata_q;
    logic                          ack_d;
    logic                          undef_d;
    logic                          trap_d;
    logic [`LPPC_XFER_W-1:0]       rdata_d;

    // ------------------------------------------------------------------------
    // Coordinate decode
    // ------------------------------------------------------------------------
    wire logic                     space_ok;
    wire logic                     common_ok;
    wire logic                     hit_miss;
    wire logic                     hit_part;
    wire logic                     hit_power;
    lppc_pkg::lppc_sel_t           sel;

    // Both views share one decode; only the space check differs between them.
    // one decode for both views
    assign space_ok  = acc_view64_i ? (acc_op0_i == `LPPC_OP0_SYSREG)
                                    : (acc_coproc_i == `LPPC_COPROC_NUM);
    assign common_ok = space_ok
                     && (acc_op1_i == `LPPC_OP1_NUM)
                     && (acc_crn_i == `LPPC_CRN_NUM);
    assign hit_miss  = common_ok
                     && (acc_crm_i == `LPPC_CRM_COUNTERS)
                     && (acc_op2_i == `LPPC_OP2_MISS);
    assign hit_part  = common_ok
                     && (acc_crm_i == `LPPC_CRM_COUNTERS)
                     && (acc_op2_i == `LPPC_OP2_PARTITION);
    assign hit_power = common_ok
                     && (acc_crm_i == `LPPC_CRM_CONTROL)
                     && (acc_op2_i == `LPPC_OP2_POWER);

    // Coordinates that hit none of the three registers are answered as undefined.
    always_comb begin
        if (hit_miss) begin
            sel = lppc_pkg::LPPC_SEL_MISS;
        end else if (hit_part) begin
            sel = lppc_pkg::LPPC_SEL_PART;
        end else if (hit_power) begin
            sel = lppc_pkg::LPPC_SEL_POWER;
        end else begin
            sel = lppc_pkg::LPPC_SEL_NONE;
        end
    end

    // ------------------------------------------------------------------------
    // Privilege checks
    // ------------------------------------------------------------------------
    wire logic                     is_el0;
    wire logic                     is_el1;
    wire logic                     power_wr_ok;
    wire logic                     part_wr_ok;
    wire logic                     sel_wr_ok;
    wire logic                     acc_legal;
    wire logic                     wr_commit;

    assign is_el0 = (acc_el_i == lppc_pkg::LPPC_EL0);
    assign is_el1 = (acc_el_i == lppc_pkg::LPPC_EL1);

    // The enables only restrict EL1; writes from EL2 and EL3 are never gated.
    // counter and power write gate
    assign power_wr_ok = !is_el1
                       || (top_level_power_reg_write_en_i && hyp_level_power_reg_write_en_i)
                       || (top_level_power_reg_write_en_i && !nonsecure_state_flag_i);
    assign part_wr_ok  = !is_el1
                       || (top_level_partition_write_en_i && hyp_level_partition_write_en_i)
                       || (top_level_partition_write_en_i && !nonsecure_state_flag_i);

    // A refused EL1 write traps rather than reporting undefined, so software can
    // tell a locked register from an absent one.
    assign sel_wr_ok = (sel == lppc_pkg::LPPC_SEL_PART) ? part_wr_ok : power_wr_ok;
    assign acc_legal = acc_valid_i && !is_el0 && (sel != lppc_pkg::LPPC_SEL_NONE);
    assign wr_commit = acc_legal && acc_write_i && sel_wr_ok;

    // ------------------------------------------------------------------------
    // Miss counter
    // ------------------------------------------------------------------------
    wire logic                     miss_counts;
    wire logic                     miss_load;
    wire logic                     miss_full;
    wire logic                     miss_bump;

    assign miss_counts = miss_event_i && (secure_event_count_enable_i || !miss_secure_i);
    assign miss_load   = wr_commit && (sel == lppc_pkg::LPPC_SEL_MISS);
    assign miss_full   = (miss_q == `LPPC_MISS_MAX);
    assign miss_bump   = miss_counts && !miss_full;

    // A load in the same cycle as a miss takes the written value; the miss is
    // dropped so that software sees exactly what it wrote.
    always_comb begin
        if (miss_load) begin
            miss_d = acc_wdata_i[`LPPC_REG_W-1:0];
        end else if (miss_bump) begin
            miss_d = miss_q + `LPPC_REG_W'(1);
        end else begin
            miss_d = miss_q;
        end
    end

    // ------------------------------------------------------------------------
    // Partition and power control
    // ------------------------------------------------------------------------
    wire logic                     part_load;
    wire logic                     power_load;

    assign part_load  = wr_commit && (sel == lppc_pkg::LPPC_SEL_PART);
    assign power_load = wr_commit && (sel == lppc_pkg::LPPC_SEL_POWER);

    // one bit per scheme and group
    assign part_d = part_load ? acc_wdata_i[SCHEMES*GROUPS-1:0] : part_q;

    assign portion_d = power_load
                     ? acc_wdata_i[`LPPC_PORTION_MSB:`LPPC_PORTION_LSB]
                     : portion_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            miss_q    <= `LPPC_MISS_RESET;
            part_q    <= (SCHEMES*GROUPS)'(`LPPC_PART_RESET);
            // The init pins are followed for as long as reset is held, so the
            // controller never sees a stale request on release.
            // reset from channel state
            portion_q <= pchannel_init_portion_i;
        end else begin
            miss_q    <= miss_d;
            part_q    <= part_d;
            portion_q <= portion_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read data and access answer
    // ------------------------------------------------------------------------
    logic [`LPPC_REG_W-1:0]        read_word;
    logic [`LPPC_REG_W-1:0]        power_word;
    wire logic                     rd_fire;

    always_comb begin
        power_word = '0;
        power_word[`LPPC_PORTION_MSB:`LPPC_PORTION_LSB] = portion_q;
    end

    always_comb begin
        case (sel)
            lppc_pkg::LPPC_SEL_MISS: begin
                read_word = miss_q;
            end
            lppc_pkg::LPPC_SEL_PART: begin
                read_word = `LPPC_REG_W'(part_q);
            end
            lppc_pkg::LPPC_SEL_POWER: begin
                read_word = power_word;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    // Reads return pre-write contents; the 64-bit view sees zero above bit 31.
    assign ack_d   = acc_valid_i;
    assign undef_d = acc_valid_i && !acc_legal;
    assign trap_d  = acc_legal && acc_write_i && !sel_wr_ok;
    // Refused accesses and writes return zero, so stale data never leaks out.
    assign rd_fire = acc_legal && !acc_write_i;
    assign rdata_d = rd_fire
                   ? {{(`LPPC_XFER_W-`LPPC_REG_W){1'b0}}, read_word}
                   : '0;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_q   <= 1'b0;
            undef_q <= 1'b0;
            trap_q  <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= ack_d;
            undef_q <= undef_d;
            trap_q  <= trap_d;
            rdata_q <= rdata_d;
        end
    end

    assign acc_ack_o   = ack_q;
    assign acc_undef_o = undef_q;
    assign acc_trap_o  = trap_q;
    assign acc_rdata_o = rdata_q;

    // ------------------------------------------------------------------------
    // Outward signals
    // ------------------------------------------------------------------------
    // drive activity bits
    // The request field is a plain register copy; nothing feeds back from the
    // power controller, so no value of it can hold off a power transition.
    // advisory, no deny path
    assign cluster_power_activity_out_o = portion_q;

    // The usable-group mask is registered and lags a partition write by a cycle.
    lppc_way_group_alloc #(
        .SCHEMES (SCHEMES),
        .GROUPS  (GROUPS)
    ) u_alloc (
        .sys_clk_i    (sys_clk_i),
        .sys_rst_i    (sys_rst_i),
        .partition_i  (part_q),
        .scheme_id_i  (alloc_scheme_i),
        .group_mask_o (alloc_group_mask_o)
    );

endmodule

/* File: rtl/lppc_way_group_alloc.sv */
`timescale 1ns/1ps
`include "lppc_regs.svh"

module lppc_way_group_alloc #(
    parameter int SCHEMES = 8,
    parameter int GROUPS  = 4
) (
    input  wire logic                         sys_clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic [SCHEMES*GROUPS-1:0]    partition_i,
    input  wire logic [$clog2(SCHEMES)-1:0]   scheme_id_i,
    output logic      [GROUPS-1:0]            group_mask_o
);

    logic [GROUPS-1:0] claimed;
    logic [GROUPS-1:0] own_groups;
    logic [GROUPS-1:0] usable;
    logic [GROUPS-1:0] group_mask_d;
    logic [GROUPS-1:0] group_mask_q;

    // ------------------------------------------------------------------------
    // Union of private claims over every scheme
    // ------------------------------------------------------------------------
    always_comb begin
        claimed = '0;
        for (int s = 0; s < SCHEMES; s++) begin
            claimed = claimed | partition_i[s*GROUPS +: GROUPS];
        end
    end

    assign own_groups = partition_i[scheme_id_i*GROUPS +: GROUPS];
    assign usable = own_groups | ~claimed;
    assign group_mask_d = (usable == '0) ? GROUPS'(`LPPC_FALLBACK_GROUP) : usable;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            group_mask_q <= '0;
        end else begin
            group_mask_q <= group_mask_d;
        end
    end

    assign group_mask_o = group_mask_q;

endmodule

/* File: testbench/lppc_pwr_ctrl_model.sv */
`timescale 1ns/1ps
module lppc_pwr_ctrl_model #(
    parameter logic [3:0] INIT_PORTION = 4'h7
) (
    input  wire logic         sys_clk_i,
    input  wire logic [19:16] activity_i,
    output logic      [3:0]   init_portion_o,
    output logic      [3:0]   granted_o
);
    assign init_portion_o = INIT_PORTION;
    // The controller powers what is asked; the request is only advisory, never a refusal.
    always_ff @(posedge sys_clk_i) begin
        granted_o <= activity_i;
    end
endmodule

/* File: testbench/lppc_regs_chk.sv */
`timescale 1ns/1ps
module lppc_regs_chk #(
    parameter int SCHEMES = 8,
    parameter int GROUPS  = 4
) (
    input  wire logic               sys_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               acc_valid_i,
    input  wire logic               acc_write_i,
    input  wire logic               acc_view64_i,
    input  wire logic [1:0]         acc_op0_i,
    input  wire logic [3:0]         acc_coproc_i,
    input  wire logic [2:0]         acc_op1_i,
    input  wire logic [3:0]         acc_crn_i,
    input  wire logic [3:0]         acc_crm_i,
    input  wire logic [2:0]         acc_op2_i,
    input  wire logic [1:0]         acc_el_i,
    input  wire logic               acc_ack_o,
    input  wire logic               acc_undef_o,
    input  wire logic               acc_trap_o,
    input  wire logic [63:0]        acc_rdata_o,
    input  wire logic               top_level_power_reg_write_en_i,
    input  wire logic               hyp_level_power_reg_write_en_i,
    input  wire logic               nonsecure_state_flag_i,
    input  wire logic [GROUPS-1:0]  alloc_group_mask_o,
    input  wire logic [3:0]         pchannel_init_portion_i,
    input  wire logic [19:16]       cluster_power_activity_out_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic base_ok = acc_valid_i && acc_op1_i == 3'h0 && acc_crn_i == 4'hF && acc_el_i != 2'h0
                         && (acc_view64_i ? acc_op0_i == 2'h3 : acc_coproc_i == 4'hF);
    wire logic miss_hit = base_ok && acc_crm_i == 4'h4 && acc_op2_i == 3'h6;
    wire logic part_hit = base_ok && acc_crm_i == 4'h4 && acc_op2_i == 3'h3;
    wire logic pwr_rd = base_ok && !acc_write_i && acc_crm_i == 4'h3 && acc_op2_i == 3'h5;
    wire logic pwr_ok = top_level_power_reg_write_en_i
                        && (hyp_level_power_reg_write_en_i || !nonsecure_state_flag_i);
    AST_ACK_ONE: assert property (acc_valid_i |=> acc_ack_o) else $error("no ack");
    AST_ACK_ONLY: assert property (!acc_valid_i |=> !acc_ack_o && !acc_undef_o && !acc_trap_o)
        else $error("stray answer");
    AST_EL0_UNDEF: assert property (acc_valid_i && acc_el_i == 2'h0 |=> acc_undef_o &&
        acc_rdata_o == 64'h0) else $error("user access not refused");
    AST_MISS_DECODE: assert property (miss_hit |=> !acc_undef_o)
        else $error("counter unmapped");
    AST_PART_DECODE: assert property (part_hit |=> !acc_undef_o)
        else $error("partition unmapped");
    AST_EL1_GATE: assert property (miss_hit && acc_write_i && acc_el_i == 2'h1 |=>
        acc_trap_o == !$past(pwr_ok)) else $error("counter write gate wrong");
    AST_VIEW_UPPER: assert property (acc_ack_o |-> acc_rdata_o[63:32] == 32'h0)
        else $error("upper read data not zero");
    AST_PWR_RAZ: assert property (pwr_rd |=> acc_rdata_o[31:8] == 24'h0 && !acc_rdata_o[3])
        else $error("power reserved bits not zero");
    AST_PWR_FIELD: assert property (pwr_rd |=>
        acc_rdata_o[7:4] == cluster_power_activity_out_o)
        else $error("activity differs from portion field");
    AST_MASK_SOME: assert property (!$past(sys_rst_i) |-> alloc_group_mask_o != '0)
        else $error("empty allocation mask");
    AST_PORTION_INIT: assert property ($past(sys_rst_i) |->
        cluster_power_activity_out_o == $past(pchannel_init_portion_i)) else $error("bad init");
endmodule
bind lppc_regs_top lppc_regs_chk #(.SCHEMES(SCHEMES), .GROUPS(GROUPS)) i_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .acc_valid_i(acc_valid_i),
    .acc_write_i(acc_write_i), .acc_view64_i(acc_view64_i), .acc_op0_i(acc_op0_i),
    .acc_coproc_i(acc_coproc_i), .acc_op1_i(acc_op1_i), .acc_crn_i(acc_crn_i),
    .acc_crm_i(acc_crm_i), .acc_op2_i(acc_op2_i), .acc_el_i(acc_el_i), .acc_ack_o(acc_ack_o),
    .acc_undef_o(acc_undef_o), .acc_trap_o(acc_trap_o), .acc_rdata_o(acc_rdata_o),
    .top_level_power_reg_write_en_i(top_level_power_reg_write_en_i),
    .hyp_level_power_reg_write_en_i(hyp_level_power_reg_write_en_i),
    .nonsecure_state_flag_i(nonsecure_state_flag_i), .alloc_group_mask_o(alloc_group_mask_o),
    .pchannel_init_portion_i(pchannel_init_portion_i),
    .cluster_power_activity_out_o(cluster_power_activity_out_o));

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam logic [3:0] INIT = 4'h7;
    logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, vld = 1'b0, wr = 1'b0, v64 = 1'b0;
    logic [3:0]  crm = 4'h4, coproc = 4'hF, crn = 4'hF, act, init, granted, mask;
    logic [2:0]  op2 = 3'h6, op1 = 3'h0, sid = 3'h0;
    logic [1:0]  el = 2'h3, op0 = 2'h3;
    logic [63:0] wd = 64'h0, rdata, r_data;
    logic        ack, undef, trap, r_undef, r_trap;
    logic        tpe = 1'b1, hpe = 1'b1, tse = 1'b1, hse = 1'b1, ns = 1'b1;
    logic        sec_en = 1'b0, miss = 1'b0, miss_sec = 1'b0;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    lppc_regs_top i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .acc_valid_i(vld),
        .acc_write_i(wr), .acc_view64_i(v64), .acc_op0_i(op0), .acc_coproc_i(coproc),
        .acc_op1_i(op1), .acc_crn_i(crn), .acc_crm_i(crm), .acc_op2_i(op2), .acc_el_i(el),
        .acc_wdata_i(wd), .acc_ack_o(ack), .acc_undef_o(undef), .acc_trap_o(trap),
        .acc_rdata_o(rdata), .top_level_power_reg_write_en_i(tpe),
        .hyp_level_power_reg_write_en_i(hpe), .top_level_partition_write_en_i(tse),
        .hyp_level_partition_write_en_i(hse), .nonsecure_state_flag_i(ns),
        .secure_event_count_enable_i(sec_en), .miss_event_i(miss), .miss_secure_i(miss_sec),
        .alloc_scheme_i(sid), .alloc_group_mask_o(mask), .pchannel_init_portion_i(init),
        .cluster_power_activity_out_o(act));
    lppc_pwr_ctrl_model #(.INIT_PORTION(INIT)) i_pwr (.sys_clk_i(sys_clk_i), .activity_i(act),
        .init_portion_o(init), .granted_o(granted));
    always #20 sys_clk_i = ~sys_clk_i;
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic wide, input logic [3:0] m,
                       input logic [2:0] o, input logic [1:0] lvl, input logic [63:0] d);
        @(negedge sys_clk_i);
        vld = 1'b1;
        wr = w;
        v64 = wide;
        crm = m;
        op2 = o;
        el = lvl;
        wd = d;
        @(negedge sys_clk_i);
        vld = 1'b0;
        check("ack", ack, 1'b1);
        r_data = rdata;
        r_undef = undef;
        r_trap = trap;
    endtask
    task automatic rd(input logic [3:0] m, input logic [2:0] o, input logic [63:0] exp);
        acc(1'b0, 1'b0, m, o, 2'h3, 64'h0);
        check("read", r_data, exp);
    endtask
    task automatic pulse(input logic s);
        @(negedge sys_clk_i);
        miss = 1'b1;
        miss_sec = s;
        @(negedge sys_clk_i);
        miss = 1'b0;
    endtask
    function automatic logic [3:0] exp_mask(input logic [31:0] p, input int s);
        logic [3:0] cl, r;
        cl = 4'h0;
        for (int j = 0; j < 8; j++) cl = cl | p[4*j +: 4];
        r = p[4*s +: 4] | ~cl;
        return (r == 4'h0) ? 4'h1 : r;
    endfunction
    task automatic t_masks(input logic [31:0] p);
        acc(1'b1, 1'b0, 4'h4, 3'h3, 2'h3, {32'h0, p});
        rd(4'h4, 3'h3, {32'h0, p});
        for (int s = 0; s < 8; s++) begin
            @(negedge sys_clk_i);
            sid = s[2:0];
            @(negedge sys_clk_i);
            check("mask", mask, exp_mask(p, s));
        end
    endtask
    task automatic t_reset;
        rd(4'h4, 3'h6, 64'h0);
        rd(4'h4, 3'h3, 64'h0);
        rd(4'h3, 3'h5, {56'h0, INIT, 4'h0});
        check("activity", act, INIT);
    endtask
    task automatic t_count;
        repeat (3) pulse(1'b0);
        repeat (2) pulse(1'b1);
        rd(4'h4, 3'h6, 64'h3);
        sec_en = 1'b1;
        pulse(1'b1);
        rd(4'h4, 3'h6, 64'h4);
        acc(1'b1, 1'b0, 4'h4, 3'h6, 2'h3, 64'hFFFF_FFFE);
        repeat (2) pulse(1'b0);
        rd(4'h4, 3'h6, 64'hFFFF_FFFF);
        acc(1'b1, 1'b1, 4'h4, 3'h6, 2'h2, 64'hAAAA_5555_0000_0005);
        rd(4'h4, 3'h6, 64'h5);
    endtask
    task automatic t_gate;
        logic okp, okq;
        for (int i = 0; i < 8; i++) begin
            {tpe, hpe, ns} = i[2:0];
            {hse, tse} = i[2:1];
            okp = i[2] && (i[1] || !i[0]);
            okq = i[1] && (i[2] || !i[0]);
            acc(1'b1, 1'b0, 4'h4, 3'h6, 2'h1, 64'h10 + i);
            check("trap", r_trap, !okp);
            rd(4'h4, 3'h6, okp ? 64'h10 + i : 64'h5);
            acc(1'b1, 1'b0, 4'h4, 3'h3, 2'h1, 64'h8);
            check("trap", r_trap, !okq);
            rd(4'h4, 3'h3, okq ? 64'h8 : 64'h0);
            acc(1'b1, 1'b0, 4'h4, 3'h3, 2'h3, 64'h0);
            acc(1'b1, 1'b0, 4'h4, 3'h6, 2'h3, 64'h5);
        end
        {tpe, hpe, tse, hse, ns} = 5'h1F;
    endtask
    task automatic t_refuse;
        acc(1'b1, 1'b0, 4'h4, 3'h6, 2'h0, 64'h99);
        check("undef", r_undef, 1'b1);
        rd(4'h4, 3'h6, 64'h5);
        acc(1'b0, 1'b0, 4'h5, 3'h6, 2'h3, 64'h0);
        check("undef", r_undef, 1'b1);
    endtask
    task automatic t_power;
        acc(1'b1, 1'b0, 4'h3, 3'h5, 2'h1, 64'hFFFF_FFFF);
        rd(4'h3, 3'h5, 64'hF0);
        check("activity", act, 4'hF);
        acc(1'b1, 1'b1, 4'h3, 3'h5, 2'h3, 64'h50);
        @(negedge sys_clk_i);
        check("activity", act, 4'h5);
        check("granted", granted, 4'h5);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Generous ceiling: the full sequence needs well under a thousand cycles.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_masks(32'h0);
        t_count();
        t_gate();
        t_refuse();
        t_masks(32'h0000_0411);
        t_masks(32'h0000_000F);
        t_power();
        complete_run();
    end
endmodule
